// File: logic/csu_pkg.sv
package csu_pkg;

    // register indices; byte address on the bus is four times the index
    localparam logic [7:0] CSU_UPPER_IDX = 8'hA0;
    localparam logic [7:0] CSU_LOWER_IDX = 8'hA2;
    localparam logic [7:0] CSU_PERIPH_BASE_IDX = 8'hA4;
    localparam logic [7:0] CSU_MIDRANGE_IDX = 8'hA6;
    localparam logic [7:0] CSU_MID_PERIPH_IDX = 8'hA8;
    localparam logic [7:0] CSU_STATUS_IDX = 8'hAA;

    // reset values: upper region F0000..FFFFF, three waits, ready required
    localparam logic [15:0] CSU_UPPER_RST = 16'hF003;
    localparam logic [15:0] CSU_CTRL_RST = 16'h0000;

    // field positions shared by the control registers
    localparam int CSU_WAIT_LSB = 0;
    localparam int CSU_IGN2_BIT = 2;
    localparam int CSU_IGN3_BIT = 3;
    localparam int CSU_BOUND_LSB = 8;
    localparam int CSU_MID_BASE_LSB = 9;
    localparam int CSU_PBASE_LSB = 6;
    localparam int CSU_MSIZE_LSB = 8;
    localparam int CSU_PADDR_BIT = 7;
    localparam int CSU_PMEM_BIT = 6;

    // peripheral blocks: seven blocks of 256 bytes above the base
    localparam logic [11:0] CSU_PBLOCKS = 12'h007;
    localparam logic [3:0] CSU_WAIT_MAX = 4'hF;

    typedef enum logic [2:0] {
        CSU_ST_IDLE = 3'b000,
        CSU_ST_T1 = 3'b001,
        CSU_ST_T2 = 3'b010,
        CSU_ST_T3 = 3'b011,
        CSU_ST_TW = 3'b100,
        CSU_ST_T4 = 3'b101
    } csu_tstate_t;

    // three-bit wait code of the low peripheral selects
    function automatic logic [3:0] csu_wait_decode(input logic [2:0] code);
        logic [3:0] w;
        w = 4'h0;
        case (code)
            3'h4: w = 4'h5;
            3'h5: w = 4'h7;
            3'h6: w = 4'h9;
            3'h7: w = 4'hF;
            default: w = {1'b0, code};
        endcase
        return w;
    endfunction

endpackage

// File: logic/csu_wait_if.sv
`timescale 1ns/10ps
interface csu_wait_if;
    logic clear;
    logic step;
    logic [3:0] waits;
    logic need_rdy;
    logic rdy;
    logic done;
    modport seq (input clear, input step, input waits, input need_rdy, input rdy, output done);
    modport ctl (output clear, output step, output waits, output need_rdy, output rdy, input done);
endinterface // csu_wait_if

// File: logic/csu_sync.sv
`timescale 1ns/10ps
module csu_sync
    import csu_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // level in and out
    input wire logic din,
    output logic dout
);
    logic meta_q;

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            meta_q <= 1'b0;
            dout <= 1'b0;
        end
        else
        begin
            meta_q <= din; // RULE11
            dout <= meta_q;
        end
    end
endmodule // csu_sync

// File: logic/csu_wait_seq.sv
`timescale 1ns/10ps
module csu_wait_seq
    import csu_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // sequencing with the bus state machine
    csu_wait_if.seq wif
);
    logic [3:0] pos_q;
    logic stretch_q;
    logic armed_q;
    logic rdy_ok_q;
    logic first;
    logic all_waits;

    // position 0 is t3, positions 1..n are programmed waits
    // with no waits t3 is the only sample point; a later ready must cost the extra wait
    assign first = (wif.waits == 4'h0) ? (pos_q == 4'h0) : (pos_q == 4'h1);
    assign all_waits = (pos_q >= wif.waits); // RULE8
    assign wif.done = wif.step && all_waits
                      && (!wif.need_rdy || rdy_ok_q || (first && wif.rdy) || armed_q); // RULE9

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            pos_q <= 4'h0;
        else if (wif.clear)
            pos_q <= 4'h0;
        else if (wif.step && pos_q != CSU_WAIT_MAX)
            pos_q <= pos_q + 4'h1;
    end

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            stretch_q <= 1'b0;
            armed_q <= 1'b0;
            rdy_ok_q <= 1'b0;
        end
        else if (wif.clear)
        begin
            stretch_q <= 1'b0;
            armed_q <= 1'b0;
            rdy_ok_q <= 1'b0;
        end
        else if (wif.step)
        begin
            if (first && wif.rdy)
                rdy_ok_q <= 1'b1; // RULE9
            if (first && wif.need_rdy && !wif.rdy)
                stretch_q <= 1'b1; // RULE10
            // ready seen while stretched costs one further wait
            if (stretch_q && wif.rdy)
                armed_q <= 1'b1; // RULE10
        end
    end
endmodule // csu_wait_seq

// File: logic/csu_top.sv
// Our own choices: the AHB-Lite slave port and the address map.
`timescale 1ns/10ps
// Functional notes
// RULE1 - region select asserts for every cycle in range, processor or dma alike; here midrange select stays off where upper or lower also hits
// RULE2 - each peripheral select covers its own 256-byte block above one base
// RULE3 - writing a select control register enables its decode, ready and wait logic
// RULE4 - upper and lower selects assert with the address at t1
// RULE5 - each control register holds one bit: external ready required or ignored
// RULE6 - upper, lower, midrange, peripheral five and six use two-bit wait fields
// RULE7 - low peripheral selects use three-bit wait code adding 5, 7, 9, 15
// RULE8 - programmed waits always finish before ready may end or stretch a cycle
// RULE9 - ready sampled in first wait; if high, cycle ends after programmed waits
// RULE10 - ready low at first wait stretches until seen, then one more wait
// RULE11 - asynchronous ready is active high and synchronised internally
// RULE12 - the far side syncs the falling edge of asynchronous ready
// RULE13 - first fetch at top boot address hits upper select with three waits
// RULE14 - latched address bits one and two can replace peripheral five and six
// RULE15 - after reset upper select covers F0000 to FFFFF with ready required
// RULE16 - lower select stays inactive after reset until its register is written
// RULE17 - software gives overlapping selects identical ready and wait settings
// RULE18 - cycle is t1 to t4; waits sit between t3 and t4
module csu_top
    import csu_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // register bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // bus cycles from core or dma
    input wire logic cyc_req,
    input wire logic [19:0] cyc_addr,
    input wire logic cyc_io,
    input wire logic cyc_dma,
    output logic cyc_done,
    output logic cyc_busy,
    // external ready
    input wire logic async_ready_in,
    input wire logic sync_ready_in,
    // select pins, active low
    output logic upper_mem_select_n,
    output logic lower_mem_select_n,
    output logic [3:0] midrange_mem_selects_n,
    output logic periph_select_six_n,
    output logic periph_select_five_n,
    output logic [3:0] low_periph_selects_n
);
    csu_wait_if wif ();

    csu_tstate_t st_q;
    logic [15:0] upper_q;
    logic [15:0] lower_q;
    logic [15:0] pbase_q;
    logic [15:0] mid_q;
    logic [15:0] mperi_q;
    logic lower_en_q;
    logic mid_en_q;
    logic per_en_q;
    logic last_dma_q;
    logic wr_pend_q;
    logic [7:0] wr_idx_q;
    logic [19:0] addr_q;
    logic hit_up_q;
    logic hit_lo_q;
    logic hit_mid_q;
    logic [1:0] mid_quad_q;
    logic hit_per_q;
    logic [2:0] per_blk_q;
    logic [3:0] waits_q;
    logic need_q;
    logic async_rdy_s;
    logic addr_ph;
    logic take;
    logic [7:0] rd_idx;
    logic [15:0] rd_val;
    logic hit_up;
    logic hit_lo;
    logic hit_mid;
    logic [6:0] mid_mask;
    logic [1:0] mid_quad;
    logic [11:0] per_off;
    logic hit_per;
    logic per_addr_mode;
    logic [3:0] waits_d;
    logic need_d;

    csu_sync u_async_ready_in_sync (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .din(async_ready_in),
        .dout(async_rdy_s)
    );

    csu_wait_seq u_wait (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .wif(wif)
    );

    // register bus slave: zero wait states, always okay
    assign addr_ph = hsel && htrans[1] && hready;
    assign rd_idx = haddr[9:2];

    always_comb
    begin
        case (rd_idx)
            CSU_UPPER_IDX: rd_val = upper_q;
            CSU_LOWER_IDX: rd_val = lower_q;
            CSU_PERIPH_BASE_IDX: rd_val = pbase_q;
            CSU_MIDRANGE_IDX: rd_val = mid_q;
            CSU_MID_PERIPH_IDX: rd_val = mperi_q;
            CSU_STATUS_IDX: rd_val = {5'h00, st_q, 3'h0, last_dma_q, cyc_busy, per_en_q, mid_en_q, lower_en_q};
            default: rd_val = 16'h0000;
        endcase
        if (haddr[31:10] != 22'h00_0000)
            rd_val = 16'h0000;
        // a read straight after a write sees the new value
        else if (wr_pend_q && wr_idx_q == rd_idx && rd_idx != CSU_STATUS_IDX)
            rd_val = hwdata[15:0];
    end

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            hrdata <= 32'h0000_0000;
            wr_pend_q <= 1'b0;
            wr_idx_q <= 8'h00;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            wr_pend_q <= addr_ph && hwrite && (haddr[31:10] == 22'h00_0000);
            if (addr_ph)
                wr_idx_q <= rd_idx;
            if (addr_ph && !hwrite)
                hrdata <= {16'h0000, rd_val};
        end
    end

    // control registers; a write to lower, peripheral base or midrange also enables that region's logic
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            upper_q <= CSU_UPPER_RST; // RULE15
            lower_q <= CSU_CTRL_RST;
            pbase_q <= CSU_CTRL_RST;
            mid_q <= CSU_CTRL_RST;
            mperi_q <= CSU_CTRL_RST;
            lower_en_q <= 1'b0; // RULE16
            mid_en_q <= 1'b0;
            per_en_q <= 1'b0;
        end
        else if (wr_pend_q)
        begin
            case (wr_idx_q)
                CSU_UPPER_IDX: upper_q <= hwdata[15:0];
                CSU_LOWER_IDX:
                begin
                    lower_q <= hwdata[15:0];
                    lower_en_q <= 1'b1; // RULE3
                end
                CSU_PERIPH_BASE_IDX:
                begin
                    pbase_q <= hwdata[15:0];
                    per_en_q <= 1'b1; // RULE3
                end
                CSU_MIDRANGE_IDX:
                begin
                    mid_q <= hwdata[15:0];
                    mid_en_q <= 1'b1; // RULE3
                end
                CSU_MID_PERIPH_IDX: mperi_q <= hwdata[15:0];
                default: ;
            endcase
        end
    end

    // address decode; source of the cycle plays no part
    assign per_addr_mode = !mperi_q[CSU_PADDR_BIT];
    assign hit_up = !cyc_io && (cyc_addr[19:12] >= upper_q[CSU_BOUND_LSB +: 8]); // RULE1
    assign hit_lo = lower_en_q && !cyc_io && (cyc_addr[19:12] <= lower_q[CSU_BOUND_LSB +: 8]); // RULE1
    assign mid_mask = 7'((8'h01 << mperi_q[CSU_MSIZE_LSB +: 3]) - 8'h01);
    assign hit_mid = mid_en_q && !cyc_io && !hit_up && !hit_lo
                     && ((cyc_addr[19:13] & ~mid_mask) == (mid_q[CSU_MID_BASE_LSB +: 7] & ~mid_mask));
    assign mid_quad = 2'(cyc_addr >> (5'd11 + 5'(mperi_q[CSU_MSIZE_LSB +: 3])));
    assign per_off = cyc_addr[19:8] - {pbase_q[CSU_PBASE_LSB +: 10], 2'b00};
    assign hit_per = per_en_q && (cyc_io != mperi_q[CSU_PMEM_BIT]) && (per_off < CSU_PBLOCKS); // RULE2

    // wait and ready setting of the selected region
    always_comb
    begin
        waits_d = 4'h0;
        need_d = 1'b0;
        if (hit_up)
        begin
            waits_d = {2'b00, upper_q[CSU_WAIT_LSB +: 2]}; // RULE6
            need_d = !upper_q[CSU_IGN2_BIT]; // RULE5
        end
        else if (hit_lo)
        begin
            waits_d = {2'b00, lower_q[CSU_WAIT_LSB +: 2]}; // RULE6
            need_d = !lower_q[CSU_IGN2_BIT]; // RULE5
        end
        else if (hit_mid)
        begin
            waits_d = {2'b00, mid_q[CSU_WAIT_LSB +: 2]}; // RULE6
            need_d = !mid_q[CSU_IGN2_BIT]; // RULE5
        end
        else if (hit_per && per_off[2:0] >= 3'h5)
        begin
            // five and six lose their wait logic when used as address bits
            if (!per_addr_mode)
            begin
                waits_d = {2'b00, mperi_q[CSU_WAIT_LSB +: 2]}; // RULE6
                need_d = !mperi_q[CSU_IGN2_BIT]; // RULE5
            end
        end
        else if (hit_per)
        begin
            // block four has no pin but keeps its wait logic
            waits_d = csu_wait_decode(pbase_q[CSU_WAIT_LSB +: 3]); // RULE7
            need_d = !pbase_q[CSU_IGN3_BIT]; // RULE5
        end
    end

    // bus cycle state machine
    assign take = (st_q == CSU_ST_IDLE) && cyc_req;
    assign wif.clear = (st_q == CSU_ST_T2);
    assign wif.step = (st_q == CSU_ST_T3) || (st_q == CSU_ST_TW);
    assign wif.waits = waits_q;
    assign wif.need_rdy = need_q;
    assign wif.rdy = async_rdy_s || sync_ready_in; // RULE5

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            st_q <= CSU_ST_IDLE;
        else
        begin
            case (st_q)
                CSU_ST_IDLE: st_q <= take ? CSU_ST_T1 : CSU_ST_IDLE;
                CSU_ST_T1: st_q <= CSU_ST_T2; // RULE18
                CSU_ST_T2: st_q <= CSU_ST_T3;
                CSU_ST_T3: st_q <= wif.done ? CSU_ST_T4 : CSU_ST_TW; // RULE18
                CSU_ST_TW: st_q <= wif.done ? CSU_ST_T4 : CSU_ST_TW; // RULE8
                CSU_ST_T4: st_q <= CSU_ST_IDLE;
                default: st_q <= CSU_ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            addr_q <= 20'h0_0000;
            hit_up_q <= 1'b0;
            hit_lo_q <= 1'b0;
            hit_mid_q <= 1'b0;
            mid_quad_q <= 2'b00;
            hit_per_q <= 1'b0;
            per_blk_q <= 3'h0;
            waits_q <= 4'h0;
            need_q <= 1'b0;
            last_dma_q <= 1'b0;
        end
        else if (take)
        begin
            addr_q <= cyc_addr;
            hit_up_q <= hit_up; // RULE13
            hit_lo_q <= hit_lo;
            hit_mid_q <= hit_mid;
            mid_quad_q <= mid_quad;
            hit_per_q <= hit_per;
            per_blk_q <= per_off[2:0];
            waits_q <= waits_d;
            need_q <= need_d;
            last_dma_q <= cyc_dma;
        end
    end

    // select pins: upper and lower from t1, the others from t2
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            upper_mem_select_n <= 1'b1;
            lower_mem_select_n <= 1'b1;
            midrange_mem_selects_n <= 4'hF;
            low_periph_selects_n <= 4'hF;
        end
        else
        begin
            upper_mem_select_n <= !(take ? hit_up : (hit_up_q && st_q != CSU_ST_T4 && st_q != CSU_ST_IDLE)); // RULE4
            lower_mem_select_n <= !(take ? hit_lo : (hit_lo_q && st_q != CSU_ST_T4 && st_q != CSU_ST_IDLE)); // RULE4
            midrange_mem_selects_n <= 4'hF;
            low_periph_selects_n <= 4'hF;
            if (wif.clear || wif.step || st_q == CSU_ST_T1)
            begin
                if (hit_mid_q)
                    midrange_mem_selects_n[mid_quad_q] <= 1'b0; // RULE1
                if (hit_per_q && per_blk_q < 3'h4)
                    low_periph_selects_n[per_blk_q[1:0]] <= 1'b0; // RULE2
            end
        end
    end

    // peripheral five and six pins, or latched address bits one and two
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            periph_select_six_n <= 1'b1;
            periph_select_five_n <= 1'b1;
        end
        else if (per_addr_mode && per_en_q)
        begin
            periph_select_six_n <= take ? cyc_addr[2] : addr_q[2]; // RULE14
            periph_select_five_n <= take ? cyc_addr[1] : addr_q[1]; // RULE14
        end
        else
        begin
            periph_select_six_n <= !(hit_per_q && per_blk_q == 3'h6 && (wif.clear || wif.step || st_q == CSU_ST_T1));
            periph_select_five_n <= !(hit_per_q && per_blk_q == 3'h5 && (wif.clear || wif.step || st_q == CSU_ST_T1));
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cyc_done <= 1'b0;
            cyc_busy <= 1'b0;
        end
        else
        begin
            cyc_done <= wif.done; // RULE10
            cyc_busy <= take || (st_q != CSU_ST_IDLE && st_q != CSU_ST_T4);
        end
    end

    // hsize is not checked: only whole-word transfers reach this slave
    logic unused_hsize;
    assign unused_hsize = ^hsize;

endmodule // csu_top

// File: testbench/csu_top_chk.sv
`timescale 1ns/10ps
module csu_chk
    import csu_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // watched outputs
    input wire logic [31:0] hrdata,
    input wire logic hresp,
    input wire logic hreadyout,
    input wire logic cyc_done,
    input wire logic cyc_busy,
    input wire logic upper_mem_select_n,
    input wire logic lower_mem_select_n,
    input wire logic [3:0] midrange_mem_selects_n,
    input wire logic [3:0] low_periph_selects_n
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    // five and six left out: in address mode they carry latched address bits
    logic late_n;
    assign late_n = &{midrange_mem_selects_n, low_periph_selects_n};
    property p_hi_zero; hrdata[31:16] == 16'h0000 && !hresp && hreadyout; endproperty
    a_hi_zero: assert property (p_hi_zero) else $error("read data upper half not zero or bus answer not okay");
    property p_done_pulse; cyc_done |=> !cyc_done; endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("done longer than one cycle");
    // busy and selects hold through t4 and drop in the idle state after it
    property p_done_end; cyc_done |-> ($past(cyc_busy) && cyc_busy) ##1 !cyc_busy; endproperty
    a_done_end: assert property (p_done_end) else $error("busy not held through final state");
    property p_busy_fell; $fell(cyc_busy) |-> $past(cyc_done); endproperty
    a_busy_fell: assert property (p_busy_fell) else $error("busy ended without final state");
    property p_upper_t1; $fell(upper_mem_select_n) |-> $rose(cyc_busy); endproperty
    a_upper_t1: assert property (p_upper_t1) else $error("upper select not at first state");
    property p_late; $rose(cyc_busy) |-> late_n; endproperty
    a_late: assert property (p_late) else $error("mid or periph select early");
    property p_late_t2; $fell(late_n) |-> $past(cyc_busy) && cyc_busy; endproperty
    a_late_t2: assert property (p_late_t2) else $error("mid or periph select outside cycle");
    property p_min; $rose(cyc_busy) |-> !cyc_done [*3]; endproperty
    a_min: assert property (p_min) else $error("cycle shorter than four states");
    property p_t4_off; cyc_done |=> upper_mem_select_n && lower_mem_select_n && late_n; endproperty
    a_t4_off: assert property (p_t4_off) else $error("select still low after final state");
    property p_idle; !cyc_busy |-> upper_mem_select_n && lower_mem_select_n && late_n; endproperty
    a_idle: assert property (p_idle) else $error("select low with no cycle");
    c_upper: cover property (!upper_mem_select_n && cyc_busy);
    c_long: cover property (cyc_busy [*8]);
    c_periph: cover property (!(&low_periph_selects_n));
endmodule // csu_chk
bind csu_top csu_chk csu_chk_inst (.clk_sys(clk_sys), .rst_b(rst_b), .hrdata(hrdata), .hresp(hresp),
    .hreadyout(hreadyout), .cyc_done(cyc_done),
    .cyc_busy(cyc_busy), .upper_mem_select_n(upper_mem_select_n), .lower_mem_select_n(lower_mem_select_n),
    .midrange_mem_selects_n(midrange_mem_selects_n), .low_periph_selects_n(low_periph_selects_n));

// File: testbench/csu_mem_model.sv
`timescale 1ns/10ps
module csu_mem_model
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // selects on the bus, active low
    input wire logic [11:0] sel_n,
    // answer speed
    input wire logic [7:0] delay,
    input wire logic use_async,
    // ready lines
    output logic sync_ready_in,
    output logic async_ready_in
);
    logic [7:0] cnt_q;
    logic rdy;
    assign rdy = !(&sel_n) && (cnt_q >= delay);
    assign sync_ready_in = rdy && !use_async;
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            cnt_q <= 8'h00;
        else if (&sel_n)
            cnt_q <= 8'h00;
        else if (cnt_q != 8'hFF)
            cnt_q <= cnt_q + 8'h01;
    end
    // rise lands off the clock grid; fall is kept on it so no extra period appears
    always @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            async_ready_in <= 1'b0;
        else if (rdy && use_async)
            async_ready_in <= #1.3 1'b1;
        else
            async_ready_in <= 1'b0;
    end
endmodule // csu_mem_model

// File: testbench/testbench.sv
`timescale 1ns/10ps
module testbench;
    import csu_pkg::*;
    typedef struct packed {
        logic [7:0] idx;
        logic [15:0] val;
        logic [19:0] addr;
        logic io;
        logic [3:0] bit_no;
        logic ign;
        logic [4:0] len;
    } csu_row_t;
    // regions never overlap: lower, upper, midrange in memory, periphs in i/o
    localparam csu_row_t ROWS [17] = '{
        '{CSU_LOWER_IDX, 16'h0F04, 20'h0_1000, 1'b0, 4'hA, 1'b1, 5'h05},
        '{CSU_LOWER_IDX, 16'h0F01, 20'h0_FFFF, 1'b0, 4'hA, 1'b0, 5'h06},
        '{CSU_UPPER_IDX, 16'hE002, 20'hE_0000, 1'b0, 4'hB, 1'b0, 5'h07},
        '{CSU_MID_PERIPH_IDX, 16'h0086, 20'hF_FFF0, 1'b0, 4'hB, 1'b0, 5'h07},
        '{CSU_PERIPH_BASE_IDX, 16'h040F, 20'h0_4000, 1'b1, 4'h0, 1'b1, 5'h14},
        '{CSU_PERIPH_BASE_IDX, 16'h0408, 20'h0_4000, 1'b1, 4'h0, 1'b1, 5'h05},
        '{CSU_PERIPH_BASE_IDX, 16'h0409, 20'h0_4100, 1'b1, 4'h1, 1'b1, 5'h06},
        '{CSU_PERIPH_BASE_IDX, 16'h040A, 20'h0_4200, 1'b1, 4'h2, 1'b1, 5'h07},
        '{CSU_PERIPH_BASE_IDX, 16'h040B, 20'h0_4300, 1'b1, 4'h3, 1'b1, 5'h08},
        '{CSU_PERIPH_BASE_IDX, 16'h040C, 20'h0_4000, 1'b1, 4'h0, 1'b1, 5'h0A},
        '{CSU_PERIPH_BASE_IDX, 16'h040D, 20'h0_4100, 1'b1, 4'h1, 1'b1, 5'h0C},
        '{CSU_PERIPH_BASE_IDX, 16'h040E, 20'h0_4200, 1'b1, 4'h2, 1'b1, 5'h0E},
        '{CSU_MID_PERIPH_IDX, 16'h0086, 20'h0_4500, 1'b1, 4'h4, 1'b1, 5'h07},
        '{CSU_MID_PERIPH_IDX, 16'h0086, 20'h0_4600, 1'b1, 4'h5, 1'b1, 5'h07},
        '{CSU_MIDRANGE_IDX, 16'h4005, 20'h4_0000, 1'b0, 4'h6, 1'b0, 5'h06},
        '{CSU_MIDRANGE_IDX, 16'h4005, 20'h4_1800, 1'b0, 4'h9, 1'b0, 5'h06},
        '{CSU_PERIPH_BASE_IDX, 16'h0400, 20'h0_4000, 1'b1, 4'h0, 1'b0, 5'h05}
    };
    logic clk_sys, rst_b, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic cyc_req, cyc_io, cyc_dma, cyc_done, cyc_busy, async_ready_in, sync_ready_in, use_async;
    logic [19:0] cyc_addr;
    logic upper_n, lower_n, six_n, five_n;
    logic [3:0] mid_n, low_n;
    logic [11:0] sel_n, seen;
    logic [7:0] delay_q;
    int err_total, total_checks, cycles, len;
    assign hready = hreadyout;
    assign sel_n = {upper_n, lower_n, mid_n, six_n, five_n, low_n};
    csu_top csu_top_inst (.clk_sys(clk_sys), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .cyc_req(cyc_req), .cyc_addr(cyc_addr), .cyc_io(cyc_io), .cyc_dma(cyc_dma),
        .cyc_done(cyc_done), .cyc_busy(cyc_busy), .async_ready_in(async_ready_in),
        .sync_ready_in(sync_ready_in), .upper_mem_select_n(upper_n), .lower_mem_select_n(lower_n),
        .midrange_mem_selects_n(mid_n), .periph_select_six_n(six_n), .periph_select_five_n(five_n),
        .low_periph_selects_n(low_n));
    csu_mem_model csu_mem_model_inst (.clk_sys(clk_sys), .rst_b(rst_b), .sel_n(sel_n), .delay(delay_q),
        .use_async(use_async), .sync_ready_in(sync_ready_in), .async_ready_in(async_ready_in));
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic summarize;
        $display("checks=%0d errors=%0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic ahb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
        @(posedge clk_sys);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {22'h0, idx, 2'b00};
        hwrite <= wr;
        do @(posedge clk_sys); while (hready !== 1'b1);
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge clk_sys); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    task automatic run_cyc(input logic [19:0] a, input logic io, input logic [7:0] d, input logic asy);
        @(posedge clk_sys);
        delay_q <= d;
        use_async <= asy;
        cyc_addr <= a;
        cyc_io <= io;
        cyc_dma <= a[8];
        cyc_req <= 1'b1;
        seen = 12'hFFF;
        len = 0;
        do
        begin
            @(negedge clk_sys);
            len++;
            seen &= sel_n;
        end while (cyc_done !== 1'b1 && len < 60);
        @(posedge clk_sys);
        cyc_req <= 1'b0;
    endtask
    task automatic boot_check;
        ahb(1'b0, CSU_UPPER_IDX, 32'h0);
        check(rd, {16'h0, CSU_UPPER_RST});
        ahb(1'b0, CSU_LOWER_IDX, 32'h0);
        check(rd, 32'h0);
        run_cyc(20'hF_FFF0, 1'b0, 8'h00, 1'b0);
        check({20'h0, seen}, 32'h0000_07FF);
        check(len, 32'h8);
    endtask
    initial
    begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            err_total++;
            summarize();
        end
    end
    initial
    begin
        {rst_b, hsel, hwrite, cyc_req, cyc_io, cyc_dma, use_async} = 7'h00;
        haddr = 32'h0;
        hwdata = 32'h0;
        htrans = 2'b00;
        hsize = 3'b010;
        cyc_addr = 20'h0;
        delay_q = 8'h00;
        repeat (3) @(posedge clk_sys);
        rst_b <= 1'b1;
        ahb(1'b1, 8'hFF, 32'h0000_FFFF);
        ahb(1'b0, 8'hFF, 32'h0);
        check(rd, 32'h0);
        boot_check();
        for (int i = 0; i < 17; i++)
        begin
            ahb(1'b1, ROWS[i].idx, {16'h0, ROWS[i].val});
            ahb(1'b0, ROWS[i].idx, 32'h0);
            check(rd, {16'h0, ROWS[i].val});
            run_cyc(ROWS[i].addr, ROWS[i].io, ROWS[i].ign ? 8'hC8 : 8'h00, 1'b0);
            check({20'h0, seen}, {20'h0, ~(12'h001 << ROWS[i].bit_no)});
            check(len, {27'h0, ROWS[i].len});
        end
        // no waits, ready missing at t3 and seen in the next state: one more wait still follows
        run_cyc(20'h0_4000, 1'b1, 8'h02, 1'b0);
        check(len, 32'h7);
        // latched address bits in place of peripheral five and six
        ahb(1'b1, CSU_MID_PERIPH_IDX, 32'h0000_0006);
        run_cyc(20'h0_4002, 1'b1, 8'h00, 1'b0);
        check({30'h0, six_n, five_n}, 32'h1);
        check(len, 32'h5);
        ahb(1'b1, CSU_MID_PERIPH_IDX, 32'h0000_0086);
        // slow partner: ready seen late, then one more wait
        run_cyc(20'hE_0000, 1'b0, 8'h0C, 1'b0);
        check({31'h0, len >= 15 && len <= 18}, 32'h1);
        run_cyc(20'hE_0000, 1'b0, 8'h0C, 1'b1);
        check({31'h0, len >= 15 && len <= 20}, 32'h1);
        // reset in mid-cycle while waiting on a ready that never comes
        @(posedge clk_sys);
        delay_q <= 8'hC8;
        cyc_addr <= 20'hE_0000;
        cyc_req <= 1'b1;
        repeat (6) @(posedge clk_sys);
        rst_b <= 1'b0;
        cyc_req <= 1'b0;
        @(negedge clk_sys);
        check({19'h0, cyc_busy, sel_n}, 32'h0000_0FFF);
        // two edges in reset so no edge-based check sees the release step
        repeat (2) @(posedge clk_sys);
        rst_b <= 1'b1;
        boot_check();
        summarize();
    end
endmodule // testbench
